// [core/standard_timer_pkg.sv]
package standard_timer_pkg;
   // Register byte addresses, one aligned word each
   localparam logic [7:0] ADDR_CTRL0  = 8'h00;
   localparam logic [7:0] ADDR_CTRL1  = 8'h04;
   localparam logic [7:0] ADDR_CNT_LO = 8'h08;
   localparam logic [7:0] ADDR_CNT_HI = 8'h0C;
   localparam logic [7:0] ADDR_DUTY_LO = 8'h10;
   localparam logic [7:0] ADDR_DUTY_HI = 8'h14;
   localparam logic [7:0] ADDR_PERIOD = 8'h18;
   // Control 0 field positions
   localparam int C0_PAUSE_BIT = 7;
   localparam int C0_CKSEL_LSB = 4;
   localparam int C0_RUN_BIT   = 3;
   // Control 1 field positions
   localparam int C1_MODE_LSB  = 6;
   localparam int C1_PFN_LSB   = 4;
   localparam int C1_OC_BIT    = 3;
   localparam int C1_POL_BIT   = 2;
   localparam int C1_DPX_BIT   = 1;
   localparam int C1_CLR_BIT   = 0;
   // Reset values
   localparam logic [7:0]  RST_BYTE = 8'h00;
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [31:0] RST_DATA = 32'h0000_0000;
   // Clock select codes
   localparam logic [2:0] CKSEL_SYS_DIV4 = 3'h0;
   localparam logic [2:0] CKSEL_SYS      = 3'h1;
   localparam logic [2:0] CKSEL_HI_DIV16 = 3'h2;
   localparam logic [2:0] CKSEL_HI_DIV64 = 3'h3;
   localparam logic [2:0] CKSEL_SUB_A    = 3'h4;
   localparam logic [2:0] CKSEL_SUB_B    = 3'h5;
   localparam logic [2:0] CKSEL_EXT_RISE = 3'h6;
   localparam logic [2:0] CKSEL_EXT_FALL = 3'h7;
   // Divider terminal counts
   localparam logic [1:0] DIV4_LAST  = 2'h3;
   localparam logic [3:0] DIV16_LAST = 4'hF;
   localparam logic [5:0] DIV64_LAST = 6'h3F;
   // Pin function codes
   localparam logic [1:0] PFN_0 = 2'h0;
   localparam logic [1:0] PFN_1 = 2'h1;
   localparam logic [1:0] PFN_2 = 2'h2;
   localparam logic [1:0] PFN_3 = 2'h3;
   // Operating modes
   typedef enum logic [1:0] {
      MODE_CMP   = 2'b00,
      MODE_CAP   = 2'b01,
      MODE_PWM   = 2'b10,
      MODE_TIMER = 2'b11
   } mode_t;
endpackage

// [core/tick_if.sv]
`timescale 1ns/10ps
// Tick source selection and resulting counter tick
interface tick_if;
   logic [2:0] clk_sel;  // Clock select field
   logic       ext_pin;  // External clock pin level
   logic       hi_tick;  // High clock enable pulse
   logic       sub_tick; // Sub clock enable pulse
   logic       tick;     // One counter clock
   modport gen (input clk_sel, ext_pin, hi_tick, sub_tick, output tick);
   modport core (output clk_sel, ext_pin, hi_tick, sub_tick, input tick);
endinterface // tick_if

// [core/count_tick_gen.sv]
`timescale 1ns/10ps
// Prescaler turning the selected source into tick pulses
module count_tick_gen
   import standard_timer_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic rst_i,
   tick_if.gen       tif
);
   typedef struct packed {
      logic [1:0] div4;  // System clock divider
      logic [5:0] divh;  // High clock divider
      logic       ext_d; // Previous external pin level
      logic       tick;  // Registered tick
   } tick_state_t;

   tick_state_t q;
   tick_state_t n;

   ////////////////////////////////////////////////////////////////
   // Next tick and divider state
   always_comb begin
      n       = q;
      n.div4  = q.div4 + 2'h1;
      n.ext_d = tif.ext_pin;
      if (tif.hi_tick) begin
         n.divh = q.divh + 6'h01;
      end
      case (tif.clk_sel)
         CKSEL_SYS_DIV4: n.tick = (q.div4 == DIV4_LAST);
         CKSEL_SYS:      n.tick = 1'b1;
         CKSEL_HI_DIV16: n.tick = tif.hi_tick && (q.divh[3:0] == DIV16_LAST);
         CKSEL_HI_DIV64: n.tick = tif.hi_tick && (q.divh == DIV64_LAST);
         CKSEL_SUB_A,
         CKSEL_SUB_B:    n.tick = tif.sub_tick;
         CKSEL_EXT_RISE: n.tick = tif.ext_pin && !q.ext_d;
         CKSEL_EXT_FALL: n.tick = !tif.ext_pin && q.ext_d;
         default:        n.tick = 1'b0;
      endcase
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign tif.tick = q.tick;

   // Full-rate selection ticks every cycle
   sel_sys_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (tif.clk_sel == CKSEL_SYS && $past(tif.clk_sel) == CKSEL_SYS)
      |-> tif.tick)
      else $error("System clock tick missing");
endmodule // count_tick_gen

// [core/standard_timer.sv]
`timescale 1ns/10ps
// Sixteen-bit standard timer with Wishbone register access
module standard_timer
   import standard_timer_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        hi_tick_i,
   input  wire logic        sub_tick_i,
   input  wire logic        external_clock_pin_i,
   input  wire logic        capture_input_pin_i,
   output logic             timer_output_pin_o,
   output logic             inverted_output_pin_o,
   output logic             timer_irq_o
);
   typedef struct packed {
      logic        pause;      // Pause bit
      logic [2:0]  clk_sel;    // Clock select field
      logic        run;        // Run enable bit
      mode_t       mode;       // Mode field
      logic [1:0]  pin_fn;     // Pin function field
      logic        oc;         // Output control bit
      logic        pol;        // Polarity bit
      logic        dpx;        // Duty/period select bit
      logic        clr_sel;    // Clear select bit
      logic [15:0] count;      // Up-counter
      logic [15:0] duty;       // Duty compare value
      logic [7:0]  period;     // Period compare value
      logic        run_d;      // Run bit, one cycle old
      logic        lvl;        // Pin level before polarity
      logic        pulse_done; // Single pulse finished
      logic        cap_d;      // Capture pin, one cycle old
      logic        ack;        // Bus acknowledge
      logic [31:0] dat;        // Bus read data
      logic        out;        // Timer output pin
      logic        out_n;      // Inverted output pin
      logic        irq;        // Interrupt request pulse
   } timer_state_t;

   timer_state_t q;
   timer_state_t n;

   tick_if tif ();

   logic [16:0] inc;        // Counter plus one with carry
   logic        counting;   // Counter advances this cycle
   logic        run_rise;   // Run bit low-to-high
   logic        p_event;    // Period comparator match
   logic        a_event;    // Duty comparator match
   logic        ovf;        // Counter wraps past top
   logic        clr;        // Counter clears this tick
   logic        pwm_active; // PWM waveform in active phase
   logic        cap_rise;   // Capture pin rising edge
   logic        cap_fall;   // Capture pin falling edge
   logic        cap_trig;   // Capture trigger selected
   logic        wr_en;      // Bus write takes effect
   logic [7:0]  rd_byte;    // Addressed register value

   ////////////////////////////////////////////////////////////////
   // Tick source wiring
   assign tif.clk_sel  = q.clk_sel;
   assign tif.ext_pin  = external_clock_pin_i;
   assign tif.hi_tick  = hi_tick_i;
   assign tif.sub_tick = sub_tick_i;

   count_tick_gen u_tick (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .tif   (tif)
   );

   ////////////////////////////////////////////////////////////////
   // Comparators and clear decision
   always_comb begin
      inc      = {1'b0, q.count} + 17'h0_0001;
      ovf      = inc[16];
      run_rise = q.run && !q.run_d;
      counting = q.run && !q.pause && tif.tick;
      // Upper byte match; value zero lands on the wrap
      p_event  = (inc[15:0] == {q.period, 8'h00});
      // Full-width match; zero value never matches
      a_event  = (inc[15:0] == q.duty) && (q.duty != RST_WORD);
      case (q.mode)
         MODE_CMP,
         MODE_TIMER: clr = q.clr_sel ? a_event : p_event;
         MODE_PWM:   clr = q.dpx ? a_event : p_event;
         MODE_CAP:   clr = p_event;
         default:    clr = p_event;
      endcase
   end

   ////////////////////////////////////////////////////////////////
   // PWM phase and capture trigger
   always_comb begin
      if (!q.dpx) begin
         // Period from high byte, duty from full value
         pwm_active = (q.count < q.duty);
      end else begin
         // Duty from high byte, zero means whole period
         pwm_active = (q.period == RST_BYTE) ||
                      (q.count[15:8] < q.period);
      end
      cap_rise = capture_input_pin_i && !q.cap_d;
      cap_fall = !capture_input_pin_i && q.cap_d;
      case (q.pin_fn)
         PFN_0:   cap_trig = cap_rise;
         PFN_1:   cap_trig = cap_fall;
         PFN_2:   cap_trig = cap_rise || cap_fall;
         PFN_3:   cap_trig = 1'b0;
         default: cap_trig = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////
   // Read multiplexer; unmapped addresses read zero
   always_comb begin
      case (wb_adr_i)
         ADDR_CTRL0:   rd_byte = {q.pause, q.clk_sel, q.run, 3'h0};
         ADDR_CTRL1:   rd_byte = {q.mode, q.pin_fn, q.oc, q.pol,
                                  q.dpx, q.clr_sel};
         ADDR_CNT_LO:  rd_byte = q.count[7:0];
         ADDR_CNT_HI:  rd_byte = q.count[15:8];
         ADDR_DUTY_LO: rd_byte = q.duty[7:0];
         ADDR_DUTY_HI: rd_byte = q.duty[15:8];
         ADDR_PERIOD:  rd_byte = q.period;
         default:      rd_byte = RST_BYTE;
      endcase
   end

   // Write lands on the edge where the master sees ack
   assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && q.ack && wb_sel_i[0];

   ////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      n       = q;
      n.irq   = 1'b0;
      n.run_d = q.run;
      n.cap_d = capture_input_pin_i;
      // Bus handshake, ack one cycle after request
      n.ack   = wb_cyc_i && wb_stb_i && !q.ack;
      if (wb_cyc_i && wb_stb_i && !q.ack) begin
         n.dat = {24'h00_0000, rd_byte};
      end
      // Register writes; counter bytes ignore writes
      if (wr_en) begin
         case (wb_adr_i)
            ADDR_CTRL0: begin
               n.pause   = wb_dat_i[C0_PAUSE_BIT];
               n.clk_sel = wb_dat_i[C0_CKSEL_LSB +: 3];
               n.run     = wb_dat_i[C0_RUN_BIT];
            end
            ADDR_CTRL1: begin
               n.mode    = mode_t'(wb_dat_i[C1_MODE_LSB +: 2]);
               n.pin_fn  = wb_dat_i[C1_PFN_LSB +: 2];
               n.oc      = wb_dat_i[C1_OC_BIT];
               n.pol     = wb_dat_i[C1_POL_BIT];
               n.dpx     = wb_dat_i[C1_DPX_BIT];
               n.clr_sel = wb_dat_i[C1_CLR_BIT];
            end
            ADDR_DUTY_LO: n.duty[7:0]  = wb_dat_i[7:0];
            ADDR_DUTY_HI: n.duty[15:8] = wb_dat_i[7:0];
            ADDR_PERIOD:  n.period     = wb_dat_i[7:0];
            default: begin
               // Unmapped or read-only: nothing stored
            end
         endcase
      end
      // Counter
      if (run_rise) begin
         n.count = RST_WORD;
      end else if (counting) begin
         n.count = clr ? RST_WORD : inc[15:0];
         n.irq   = clr || ovf;
      end
      // Pin level per mode
      case (q.mode)
         MODE_CMP: begin
            if (run_rise) begin
               n.lvl = q.oc;
            end else if (counting && a_event) begin
               // Equal request leaves level as it is
               case (q.pin_fn)
                  PFN_1:   n.lvl = 1'b0;
                  PFN_2:   n.lvl = 1'b1;
                  PFN_3:   n.lvl = !q.lvl;
                  default: n.lvl = q.lvl;
               endcase
            end
         end
         MODE_PWM: begin
            case (q.pin_fn)
               PFN_0:   n.lvl = !q.oc;
               PFN_1:   n.lvl = q.oc;
               PFN_2:   n.lvl = pwm_active ? q.oc : !q.oc;
               PFN_3: begin
                  // Single pulse from run rise to duty match
                  if (run_rise) begin
                     n.lvl        = q.oc;
                     n.pulse_done = 1'b0;
                  end else if (!q.run || q.pulse_done) begin
                     n.lvl = !q.oc;
                  end else if (counting && a_event) begin
                     n.lvl        = !q.oc;
                     n.pulse_done = 1'b1;
                  end
               end
               default: n.lvl = q.lvl;
            endcase
         end
         MODE_CAP: begin
            // Capture stores the counter in the duty value
            if (q.run && cap_trig) begin
               n.duty = q.count;
               n.irq  = 1'b1;
            end
         end
         default: begin
            // Timer mode: pin level not used
            n.lvl = q.lvl;
         end
      endcase
      // Output pins
      if (n.mode != MODE_TIMER) begin
         n.out = n.pol ? !n.lvl : n.lvl;
      end else begin
         n.out = q.out;
      end
      n.out_n = !n.out;
   end

   ////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q       <= '0;
         // Inverse pin starts high so the pair never agrees
         q.out_n <= 1'b1;
      end else begin
         q <= n;
      end
   end

   // Outputs straight from state flip-flops
   assign wb_dat_o              = q.dat;
   assign wb_ack_o              = q.ack;
   assign timer_output_pin_o    = q.out;
   assign inverted_output_pin_o = q.out_n;
   assign timer_irq_o           = q.irq;

   ////////////////////////////////////////////////////////////////
   // Checks
   pause_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ($past(q.pause) && !$past(run_rise)) |-> q.count == $past(q.count))
      else $error("Counter moved while paused");

   run_rise_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
      run_rise |=> q.count == RST_WORD)
      else $error("Counter not cleared on run rise");

   run_off_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !q.run |=> q.count == $past(q.count))
      else $error("Counter moved while stopped");

   cmp_init_lvl_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (run_rise && q.mode == MODE_CMP) |=> q.lvl == $past(q.oc))
      else $error("Initial level not restored");

   inverse_pin_a: assert property (@(posedge clk_i) disable iff (rst_i)
      inverted_output_pin_o == !timer_output_pin_o)
      else $error("Inverted pin not inverse");

   polarity_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (q.mode != MODE_TIMER) |-> timer_output_pin_o == (q.lvl ^ q.pol))
      else $error("Polarity not applied");

   period_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (counting && !run_rise && q.mode == MODE_CMP && !q.clr_sel
       && p_event) |=> (q.count == RST_WORD) && timer_irq_o)
      else $error("Period match did not clear");

   duty_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (counting && !run_rise && q.mode == MODE_CMP && q.clr_sel
       && a_event) |=> (q.count == RST_WORD) && timer_irq_o)
      else $error("Duty match did not clear");

   toggle_match_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (counting && !run_rise && a_event && q.mode == MODE_CMP
       && q.pin_fn == PFN_3) |=> q.lvl != $past(q.lvl))
      else $error("Toggle on match missing");

   pwm_force_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (q.mode == MODE_PWM && q.pin_fn == PFN_1) |=> q.lvl == $past(q.oc))
      else $error("Forced active level wrong");

   ////////////////////////////////////////////////////////////////
   // Bus, counter and pin checks

   // Ack is a one-cycle pulse
   ack_pulse_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("Ack held longer than one cycle");

   // Timer mode leaves the pin where it was
   timer_hold_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (q.mode == MODE_TIMER) |-> $stable(timer_output_pin_o))
      else $error("Pin moved in timer mode");

   // A counting tick without clear adds one
   count_step_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (counting && !run_rise && !clr)
      |=> q.count == $past(q.count) + 16'h0001)
      else $error("Counter step wrong");

   // Any selected clear zeroes the counter and requests
   clear_irq_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (counting && !run_rise && clr)
      |=> (q.count == RST_WORD) && timer_irq_o)
      else $error("Clear without zero or request");

   // Forced inactive level in PWM mode
   pwm_idle_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (q.mode == MODE_PWM && q.pin_fn == PFN_0)
      |=> q.lvl == !$past(q.oc))
      else $error("Forced inactive level wrong");

   // Waveform follows the active phase and output control
   pwm_wave_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (q.mode == MODE_PWM && q.pin_fn == PFN_2) |=>
      q.lvl == ($past(pwm_active) ? $past(q.oc) : !$past(q.oc)))
      else $error("PWM level wrong");

   // Finished single pulse stays inactive
   pulse_end_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (q.mode == MODE_PWM && q.pin_fn == PFN_3 && !run_rise
       && q.pulse_done) |=> q.lvl == !$past(q.oc))
      else $error("Single pulse not ended");

   // Capture copies the counter and requests service
   capture_store_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (q.mode == MODE_CAP && q.run && cap_trig)
      |=> (q.duty == $past(q.count)) && timer_irq_o)
      else $error("Capture not stored");
endmodule // standard_timer

// [test/standard_timer_tb.sv]
`timescale 1ns/10ps
// Self-checking bench for the standard timer, register and pin level
module standard_timer_tb;
   import standard_timer_pkg::*;

   logic        clk_i;                 // 250 MHz system clock
   logic        rst_i;                 // Synchronous reset
   logic        wb_cyc_i;              // Bus cycle
   logic        wb_stb_i;              // Bus strobe
   logic        wb_we_i;               // Bus write enable
   logic [7:0]  wb_adr_i;              // Bus byte address
   logic [3:0]  wb_sel_i;              // Bus byte enables
   logic [31:0] wb_dat_i;              // Bus write data
   logic [31:0] wb_dat_o;              // Bus read data
   logic        wb_ack_o;              // Bus acknowledge
   logic        hi_tick_i;             // High clock enable
   logic        sub_tick_i;            // Sub clock enable
   logic        external_clock_pin_i;  // Free toggling external clock
   logic        capture_input_pin_i;   // Capture pin
   logic        timer_output_pin_o;    // Timer output
   logic        inverted_output_pin_o; // Inverse output
   logic        timer_irq_o;           // Interrupt pulse
   int          failures;              // Mismatch count
   int          checked;               // Comparison count
   int          irq_cnt;               // Interrupt pulses seen

   ////////////////////////////////////////////////////////////////////////
   standard_timer DUT (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .hi_tick_i(hi_tick_i), .sub_tick_i(sub_tick_i),
      .external_clock_pin_i(external_clock_pin_i),
      .capture_input_pin_i(capture_input_pin_i),
      .timer_output_pin_o(timer_output_pin_o),
      .inverted_output_pin_o(inverted_output_pin_o),
      .timer_irq_o(timer_irq_o));

   // Clock generator
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end

   // External pin toggles each cycle: a rising edge every two cycles
   always @(posedge clk_i) begin
      external_clock_pin_i <= ~external_clock_pin_i;
      if (timer_irq_o === 1'b1) begin
         irq_cnt <= irq_cnt + 1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Compare and report
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Verdict and end of run
   task automatic finish_test();
      if (failures == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // One classic bus cycle, held until ack is sampled at an edge
   task automatic wb_xfer(input logic w, input logic [7:0] a,
                          input logic [7:0] d, input logic [3:0] s,
                          output logic [7:0] rd);
      rd = 8'h00;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_sel_i <= s;
      wb_dat_i <= {24'h00_0000, d};
      // Request stands until ack is seen high at a rising edge
      do begin
         @(posedge clk_i);
      end while (wb_ack_o !== 1'b1);
      // Read data taken at the ack edge, then release
      rd = wb_dat_o[7:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] t;
      wb_xfer(1'b1, a, d, 4'h1, t);
   endtask

   task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
      wb_xfer(1'b0, a, 8'h00, 4'h1, v);
   endtask

   // Bounded wait for the next interrupt pulse, in cycles
   task automatic wait_irq(output int n);
      n = 0;
      do begin
         @(negedge clk_i);
         n++;
      end while (timer_irq_o !== 1'b1 && n < 20000);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Reset values, read-only counter, ignored and unmapped writes
   task automatic t_regs();
      logic [7:0] v;
      for (int i = 0; i < 8; i++) begin
         rd_reg(8'(i * 4), v);
         check(16'(v), 16'h0000);
      end
      wr_reg(ADDR_CTRL0, 8'hFF);
      rd_reg(ADDR_CTRL0, v);
      check(16'(v), 16'h00F8);
      wr_reg(ADDR_CTRL0, 8'h00);
      wr_reg(ADDR_CTRL1, 8'hA5);
      wb_xfer(1'b1, ADDR_CTRL1, 8'h00, 4'hE, v);
      rd_reg(ADDR_CTRL1, v);
      check(16'(v), 16'h00A5);
      wr_reg(ADDR_CNT_LO, 8'hAA);
      rd_reg(ADDR_CNT_LO, v);
      check(16'(v), 16'h0000);
      wr_reg(8'h1C, 8'h77);
      rd_reg(8'h1C, v);
      check(16'(v), 16'h0000);
      wr_reg(ADDR_CTRL1, 8'h00);
   endtask

   // Run rise clears, stop keeps residual, pause holds and resumes
   task automatic t_count();
      logic [7:0] a;
      logic [7:0] b;
      wr_reg(ADDR_CTRL1, 8'hC0);
      wr_reg(ADDR_CTRL0, 8'h18);
      repeat (60) @(posedge clk_i);
      wr_reg(ADDR_CTRL0, 8'h10);
      rd_reg(ADDR_CNT_LO, a);
      repeat (20) @(posedge clk_i);
      rd_reg(ADDR_CNT_LO, b);
      check(16'(b), 16'(a));
      check(16'(a > 8'd40), 16'h0001);
      wr_reg(ADDR_CTRL0, 8'h18);
      rd_reg(ADDR_CNT_LO, a);
      check(16'(a < 8'd16), 16'h0001);
      wr_reg(ADDR_CTRL0, 8'h98);
      rd_reg(ADDR_CNT_LO, a);
      repeat (20) @(posedge clk_i);
      rd_reg(ADDR_CNT_LO, b);
      check(16'(b), 16'(a));
      wr_reg(ADDR_CTRL0, 8'h18);
      rd_reg(ADDR_CNT_LO, b);
      check(16'(b > a && b < a + 8'd16), 16'h0001);
   endtask

   // Period 1 with every clock source: match every 256 ticks
   task automatic t_clksel();
      int exp_gap [8] = '{1024, 256, 4096, 16384, 256, 256, 512, 512};
      int n;
      int gap;
      wr_reg(ADDR_PERIOD, 8'h01);
      for (int i = 0; i < 8; i++) begin
         wr_reg(ADDR_CTRL0, 8'(i << 4));
         wr_reg(ADDR_CTRL0, 8'((i << 4) | 8));
         wait_irq(n);
         wait_irq(gap);
         check(16'(gap), 16'(exp_gap[i]));
      end
   endtask

   // Compare mode: initial level, match action, polarity, inverse pin
   task automatic t_cmp();
      logic [1:0] f;
      logic       oc;
      logic       pol;
      logic       lvl;
      int         n;
      wr_reg(ADDR_PERIOD, 8'h00);
      wr_reg(ADDR_DUTY_LO, 8'h10);
      for (int k = 0; k < 16; k++) begin
         f   = 2'(k);
         oc  = k[2];
         pol = k[3];
         lvl = (f == PFN_0) ? oc : (f == PFN_1) ? 1'b0 :
               (f == PFN_2) ? 1'b1 : ~oc;
         wr_reg(ADDR_CTRL0, 8'h10);
         wr_reg(ADDR_CTRL1, {2'b00, f, oc, pol, 2'b01});
         wr_reg(ADDR_CTRL0, 8'h18);
         // Run rise is seen one cycle after the write lands
         repeat (2) @(negedge clk_i);
         check(16'(timer_output_pin_o), 16'(oc ^ pol));
         wait_irq(n);
         check(16'(n < 20), 16'h0001);
         repeat (2) @(negedge clk_i);
         check(16'(timer_output_pin_o), 16'(lvl ^ pol));
         check(16'(inverted_output_pin_o), 16'(!timer_output_pin_o));
      end
   endtask

   // PWM levels, waveform, role swap, clear bit ignored, single pulse
   task automatic t_pwm();
      logic [7:0] c1  [6] = '{8'h88, 8'h98, 8'hA9, 8'hAC, 8'hAA, 8'hB8};
      int         exp [6] = '{0, 256, 64, 192, 256, 0};
      int         hi;
      logic       early;
      wr_reg(ADDR_PERIOD, 8'h01);
      wr_reg(ADDR_DUTY_LO, 8'h40);
      for (int i = 0; i < 6; i++) begin
         wr_reg(ADDR_CTRL0, 8'h10);
         wr_reg(ADDR_CTRL1, c1[i]);
         wr_reg(ADDR_CTRL0, 8'h18);
         repeat (8) @(negedge clk_i);
         early = timer_output_pin_o;
         repeat (300) @(negedge clk_i);
         hi = 0;
         repeat (256) begin
            @(negedge clk_i);
            hi += int'(timer_output_pin_o === 1'b1);
         end
         check(16'(hi), 16'(exp[i]));
         if (i == 5) begin
            check(16'(early), 16'h0001);
         end
      end
   endtask

   // Capture trigger edge selection counted through interrupts
   task automatic t_cap();
      int         exp [4] = '{1, 1, 2, 0};
      int         base;
      logic [7:0] v;
      wr_reg(ADDR_PERIOD, 8'h00);
      wr_reg(ADDR_DUTY_HI, 8'hFF);
      for (int i = 0; i < 4; i++) begin
         wr_reg(ADDR_CTRL0, 8'h10);
         wr_reg(ADDR_CTRL1, 8'(8'h40 | (i << 4)));
         wr_reg(ADDR_CTRL0, 8'h18);
         base = irq_cnt;
         repeat (10) @(posedge clk_i);
         capture_input_pin_i <= 1'b1;
         repeat (10) @(posedge clk_i);
         capture_input_pin_i <= 1'b0;
         repeat (10) @(posedge clk_i);
         check(16'(irq_cnt - base), 16'(exp[i]));
         if (i == 0) begin
            rd_reg(ADDR_DUTY_HI, v);
            check(16'(v), 16'h0000);
         end
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Watchdog cutting a hang short
   initial begin
      #300000;
      failures++;
      finish_test();
   end

   // Main sequence
   initial begin
      failures = 0;
      checked = 0;
      irq_cnt = 0;
      rst_i = 1'b1;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'h0;
      wb_dat_i = 32'h0000_0000;
      hi_tick_i = 1'b1;
      sub_tick_i = 1'b1;
      external_clock_pin_i = 1'b0;
      capture_input_pin_i = 1'b0;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_count();
      t_clksel();
      t_cmp();
      t_pwm();
      t_cap();
      finish_test();
   end
endmodule // standard_timer_tb
